// file: design/nvsr_pkg.sv
// Purpose: shared constants and types for the nonvolatile sram host controller
// Assumes: 40 MHz ref_clk, pins of an 8K x 8 static ram with nonvolatile shadow
// Notes: times kept in their own unit, cycle counts derived from the clock period
package nvsr_pkg;
  // ==========================================================
  // widths
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TMR_W = 20;
  localparam int unsigned ARRAY_BYTES = 8192;
  localparam int unsigned SYNC_STAGES = 3;

  // ==========================================================
  // clock and times
  localparam longint unsigned CLK_PERIOD_PS = 25000;
  localparam longint unsigned ACCESS_NS = 55;
  localparam longint unsigned WRITE_PULSE_NS = 45;
  localparam longint unsigned STORE_INIT_NS = 20;
  localparam longint unsigned RECALL_INIT_NS = 20;
  localparam longint unsigned RECALL_US = 20;
  localparam longint unsigned STORE_MS = 10;
  localparam longint unsigned RESTORE_US = 550;

  // least wait: round up, never below one cycle
  function automatic int unsigned nvsr_cycles(input longint unsigned ps);
    longint unsigned c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c == 0) begin
      c = 1;
    end
    return int'(c);
  endfunction

  localparam int unsigned ACCESS_CYC = nvsr_cycles(ACCESS_NS * 1000) + SYNC_STAGES;
  localparam int unsigned WRITE_PULSE_CYC = nvsr_cycles(WRITE_PULSE_NS * 1000);
  localparam int unsigned STORE_INIT_CYC = nvsr_cycles(STORE_INIT_NS * 1000);
  localparam int unsigned RECALL_INIT_CYC = nvsr_cycles(RECALL_INIT_NS * 1000);
  localparam int unsigned RECALL_CYC = nvsr_cycles(RECALL_US * 1000000);
  localparam int unsigned STORE_CYC_DEF = nvsr_cycles(STORE_MS * 1000000000);
  localparam int unsigned RESTORE_CYC_DEF = nvsr_cycles(RESTORE_US * 1000000);

  // ==========================================================
  // commands
  typedef enum logic [1:0] {
    NVSR_OP_READ,
    NVSR_OP_WRITE,
    NVSR_OP_STORE,
    NVSR_OP_RECALL
  } nvsr_op_e;
endpackage

// file: design/nvsr_tmr_if.sv
// Purpose: carrier between the sequencer and its wait timer
// Assumes: one clock domain
// Notes: start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ps
interface nvsr_tmr_if;
  logic start;
  logic [nvsr_pkg::TMR_W-1:0] count;
  logic done;
  modport ctrl (output start, output count, input done);
  modport tmr (input start, input count, output done);
endinterface

// file: design/nvsr_timer.sv
// Purpose: down counter timing the restore, read, write pulse, nonvolatile initiation and transfer waits of the host sequencer
// Assumes: count is at least one
// Notes: done pulses count+1 cycles after start; a new start restarts it
`timescale 1ns/1ps
module nvsr_timer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  nvsr_tmr_if.tmr t
);
  logic [nvsr_pkg::TMR_W-1:0] cnt_reg, cnt_next;
  logic run_reg, run_next;
  logic done_reg, done_next;

  // ==========================================================
  // next state
  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    done_next = 1'b0;
    if (t.start) begin
      cnt_next = t.count;
      run_next = 1'b1;
    end else if (run_reg) begin
      if (cnt_reg <= nvsr_pkg::TMR_W'(1)) begin
        run_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - nvsr_pkg::TMR_W'(1);
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      done_reg <= done_next;
    end
  end

  assign t.done = done_reg;
endmodule // nvsr_timer

// file: design/nvsr_host.sv
// Purpose: host controller driving the pins of a nonvolatile static ram
// Assumes: supply monitor gives power_good; pins asynchronous to ref_clk
// Notes: one command at a time; waits are the worst-case device times
`timescale 1ns/1ps
module nvsr_host #(
  parameter int unsigned STORE_CYC = nvsr_pkg::STORE_CYC_DEF,
  parameter int unsigned RESTORE_CYC = nvsr_pkg::RESTORE_CYC_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // supply monitor, asynchronous
  input wire logic power_good,
  // command port
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [nvsr_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [nvsr_pkg::DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [nvsr_pkg::DATA_W-1:0] rsp_rdata,
  output logic busy,
  // device pins
  output logic [nvsr_pkg::ADDR_W-1:0] addr_lines,
  input wire logic [nvsr_pkg::DATA_W-1:0] data_lines_in,
  output logic [nvsr_pkg::DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  output logic chip_sel_n,
  output logic out_gate_n,
  output logic write_n,
  output logic nv_select_n
);
  typedef enum logic [3:0] {
    ST_PWR, ST_RESTORE, ST_IDLE, ST_RD, ST_RD_CAP, ST_WR_SET, ST_WR_PULSE,
    ST_WR_HOLD, ST_NV_SET, ST_NV_TRIG, ST_NV_WAIT
  } nvsr_state_e;

  nvsr_tmr_if tif ();

  nvsr_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .t(tif.tmr)
  );

  // ==========================================================
  // input synchronisers
  logic [2:0] pg_sync_reg, pg_sync_next;
  logic pg_ok_reg, pg_ok_next;
  logic [nvsr_pkg::DATA_W-1:0] d1_reg, d2_reg, d3_reg;

  always_comb begin
    pg_sync_next = {pg_sync_reg[1:0], power_good};
    pg_ok_next = pg_ok_reg;
    if (pg_sync_reg[1] == pg_sync_reg[2]) begin
      pg_ok_next = pg_sync_reg[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pg_sync_reg <= 3'h0;
      pg_ok_reg <= 1'b0;
      d1_reg <= 8'h00;
      d2_reg <= 8'h00;
      d3_reg <= 8'h00;
    end else begin
      pg_sync_reg <= pg_sync_next;
      pg_ok_reg <= pg_ok_next;
      d1_reg <= data_lines_in;
      d2_reg <= d1_reg;
      d3_reg <= d2_reg;
    end
  end

  // ==========================================================
  // sequencer
  nvsr_state_e state_reg, state_next;
  logic is_store_reg, is_store_next;
  logic [nvsr_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [nvsr_pkg::DATA_W-1:0] dout_reg, dout_next;
  logic [nvsr_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic doe_reg, doe_next;
  logic cs_n_reg, cs_n_next;
  logic og_n_reg, og_n_next;
  logic we_n_reg, we_n_next;
  logic nv_n_reg, nv_n_next;
  logic rv_reg, rv_next;
  logic rerr_reg, rerr_next;
  logic ready_reg, ready_next;
  logic tstart_reg, tstart_next;
  logic [nvsr_pkg::TMR_W-1:0] tcount_reg, tcount_next;

  function automatic logic [nvsr_pkg::TMR_W-1:0] tc(input int unsigned n);
    return nvsr_pkg::TMR_W'(n);
  endfunction

  always_comb begin
    state_next = state_reg;
    is_store_next = is_store_reg;
    addr_next = addr_reg;
    dout_next = dout_reg;
    rdata_next = rdata_reg;
    doe_next = doe_reg;
    cs_n_next = cs_n_reg;
    og_n_next = og_n_reg;
    we_n_next = we_n_reg;
    nv_n_next = nv_n_reg;
    rv_next = 1'b0;
    rerr_next = 1'b0;
    tstart_next = 1'b0;
    tcount_next = tcount_reg;
    case (state_reg)
      ST_PWR: begin
        if (pg_ok_reg) begin
          // the device recalls on its own once supply is up
          state_next = ST_RESTORE;
          tstart_next = 1'b1;
          tcount_next = tc(RESTORE_CYC);
        end
      end
      ST_RESTORE: begin
        if (tif.done) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cmd_valid) begin
          addr_next = cmd_addr;
          dout_next = cmd_wdata;
          case (nvsr_pkg::nvsr_op_e'(cmd_op))
            nvsr_pkg::NVSR_OP_READ: begin
              // read state: cs, oe low, nv, we high
              cs_n_next = 1'b0;
              og_n_next = 1'b0;
              state_next = ST_RD;
              tstart_next = 1'b1;
              tcount_next = tc(nvsr_pkg::ACCESS_CYC);
            end
            nvsr_pkg::NVSR_OP_WRITE: begin
              state_next = ST_WR_SET; // address settles first
            end
            nvsr_pkg::NVSR_OP_STORE: begin
              if (pg_ok_reg) begin
                // nv and cs low, we high, oe high: no operation yet
                is_store_next = 1'b1;
                nv_n_next = 1'b0;
                cs_n_next = 1'b0;
                state_next = ST_NV_SET;
              end else begin
                rv_next = 1'b1; // low supply: device would refuse it
                rerr_next = 1'b1;
              end
            end
            default: begin
              // recall set-up with cs high so cs enters last
              is_store_next = 1'b0;
              nv_n_next = 1'b0;
              og_n_next = 1'b0;
              state_next = ST_NV_SET;
            end
          endcase
        end
      end
      ST_RD: begin
        if (tif.done) begin
          state_next = ST_RD_CAP;
        end
      end
      ST_RD_CAP: begin
        // settled data only: second and third stage agree
        if (d2_reg == d3_reg) begin
          rdata_next = d3_reg;
          rv_next = 1'b1;
          cs_n_next = 1'b1;
          og_n_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_WR_SET: begin
        // output gate stays high so both ends never drive
        cs_n_next = 1'b0;
        we_n_next = 1'b0;
        doe_next = 1'b1;
        state_next = ST_WR_PULSE;
        tstart_next = 1'b1;
        tcount_next = tc(nvsr_pkg::WRITE_PULSE_CYC);
      end
      ST_WR_PULSE: begin
        if (tif.done) begin
          cs_n_next = 1'b1;
          we_n_next = 1'b1;
          state_next = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        // address and data held one cycle past the strobe rise
        doe_next = 1'b0;
        rv_next = 1'b1;
        state_next = ST_IDLE;
      end
      ST_NV_SET: begin
        if (is_store_reg) begin
          we_n_next = 1'b0; // write strobe last into store state
          tcount_next = tc(nvsr_pkg::STORE_INIT_CYC);
        end else begin
          cs_n_next = 1'b0; // fresh transition re-arms the device
          tcount_next = tc(nvsr_pkg::RECALL_INIT_CYC);
        end
        state_next = ST_NV_TRIG;
        tstart_next = 1'b1;
      end
      ST_NV_TRIG: begin
        if (tif.done) begin
          // initiation held long enough; release cs, oe, we and nv together
          cs_n_next = 1'b1;
          og_n_next = 1'b1;
          we_n_next = 1'b1;
          nv_n_next = 1'b1;
          state_next = ST_NV_WAIT;
          tstart_next = 1'b1;
          // device ignores pins for the whole transfer
          tcount_next = is_store_reg ? tc(STORE_CYC) : tc(nvsr_pkg::RECALL_CYC);
        end
      end
      ST_NV_WAIT: begin
        // pins idle with cs high until the transfer must be over
        if (tif.done) begin
          rv_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_PWR;
      end
    endcase
    if (!pg_ok_reg && state_reg != ST_PWR) begin
      // supply loss: deselect and wait for the automatic recall again
      state_next = ST_PWR;
      cs_n_next = 1'b1;
      og_n_next = 1'b1;
      we_n_next = 1'b1;
      nv_n_next = 1'b1;
      doe_next = 1'b0;
      rv_next = 1'b0;
      rerr_next = 1'b0;
    end
    ready_next = (state_next == ST_IDLE) && !(state_reg == ST_IDLE && cmd_valid && ready_reg);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_PWR;
      is_store_reg <= 1'b0;
      addr_reg <= 13'h0000;
      dout_reg <= 8'h00;
      rdata_reg <= 8'h00;
      doe_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      og_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      nv_n_reg <= 1'b1;
      rv_reg <= 1'b0;
      rerr_reg <= 1'b0;
      ready_reg <= 1'b0;
      tstart_reg <= 1'b0;
      tcount_reg <= 20'h00001;
    end else begin
      state_reg <= state_next;
      is_store_reg <= is_store_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      rdata_reg <= rdata_next;
      doe_reg <= doe_next;
      cs_n_reg <= cs_n_next;
      og_n_reg <= og_n_next;
      we_n_reg <= we_n_next;
      nv_n_reg <= nv_n_next;
      rv_reg <= rv_next;
      rerr_reg <= rerr_next;
      ready_reg <= ready_next;
      tstart_reg <= tstart_next;
      tcount_reg <= tcount_next;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign tif.start = tstart_reg;
  assign tif.count = tcount_reg;
  assign cmd_ready = ready_reg;
  assign rsp_valid = rv_reg;
  assign rsp_err = rerr_reg;
  assign rsp_rdata = rdata_reg;
  assign busy = ~ready_reg;
  assign addr_lines = addr_reg;
  assign data_lines_out = dout_reg;
  assign data_lines_oe = doe_reg;
  assign chip_sel_n = cs_n_reg;
  assign out_gate_n = og_n_reg;
  assign write_n = we_n_reg;
  assign nv_select_n = nv_n_reg;
endmodule // nvsr_host

// file: tb/nvsr_host_chk_asserts.sv
// Purpose: pin protocol checker for the nvsr host
// Assumes: single ref_clk domain
// Notes: nonvolatile waits checked against the host's own parameters
`timescale 1ns/1ps
module nvsr_host_chk #(
  parameter int unsigned STORE_CYC = 20
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // status
  input wire logic power_good,
  input wire logic cmd_ready,
  // device pins
  input wire logic [nvsr_pkg::ADDR_W-1:0] addr_lines,
  input wire logic data_lines_oe,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic write_n,
  input wire logic nv_select_n
);
  // ==========================================================
  // helpers
  wire st = !nv_select_n && !chip_sel_n && !write_n && out_gate_n;
  wire rc = !nv_select_n && !chip_sel_n && !out_gate_n && write_n;
  logic st_reg, st_next, rc_reg, rc_next;
  int unsigned wait_reg, wait_next;
  always_comb begin
    st_next = st;
    rc_next = rc;
    wait_next = (wait_reg != 0) ? wait_reg - 1 : 0;
    if (st_reg && !st) begin
      wait_next = STORE_CYC;
    end else if (rc_reg && !rc) begin
      wait_next = nvsr_pkg::RECALL_CYC;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= 1'b0;
      rc_reg <= 1'b0;
      wait_reg <= 0;
    end else begin
      st_reg <= st_next;
      rc_reg <= rc_next;
      wait_reg <= wait_next;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // properties
  property p_rst_idle;
    disable iff (1'b0) rst |=> chip_sel_n && write_n && nv_select_n && out_gate_n
      && !data_lines_oe && !cmd_ready;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pins active after reset");
  property p_idle_desel;
    cmd_ready |-> chip_sel_n && !data_lines_oe;
  endproperty
  a_idle_desel: assert property (p_idle_desel) else $error("idle but selected");
  property p_write_gate;
    (!chip_sel_n && !write_n && nv_select_n) |-> out_gate_n;
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("gate low in write");
  property p_oe_write;
    data_lines_oe |-> nv_select_n && out_gate_n;
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("bus driven outside write");
  property p_addr_hold;
    (!chip_sel_n && !write_n && nv_select_n) |-> $stable(addr_lines);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in write");
  property p_store_last;
    (st && !$past(st)) |-> $past(!chip_sel_n && !nv_select_n && out_gate_n);
  endproperty
  a_store_last: assert property (p_store_last) else $error("store not strobe-last");
  property p_store_release;
    (st && !$past(st)) |-> ##[1:4] (chip_sel_n && write_n && nv_select_n);
  endproperty
  a_store_release: assert property (p_store_release) else $error("store init stuck");
  property p_recall_last;
    (rc && !$past(rc)) |-> $past(!nv_select_n && !out_gate_n && chip_sel_n && write_n);
  endproperty
  a_recall_last: assert property (p_recall_last) else $error("recall not select-last");
  property p_recall_we;
    (!nv_select_n && !out_gate_n) |-> write_n;
  endproperty
  a_recall_we: assert property (p_recall_we) else $error("strobe low in recall");
  property p_quiet;
    wait_reg != 0 |-> chip_sel_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("access during transfer");
  property p_power;
    $fell(power_good) |-> ##[1:8] (chip_sel_n && !cmd_ready);
  endproperty
  a_power: assert property (p_power) else $error("no abort on power loss");
  c_store: cover property (st && !$past(st));
  c_recall: cover property (rc && !$past(rc));
  c_write: cover property (data_lines_oe && !write_n);
endmodule // nvsr_host_chk

bind nvsr_host nvsr_host_chk #(.STORE_CYC(STORE_CYC)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .power_good(power_good), .cmd_ready(cmd_ready), .addr_lines(addr_lines),
  .data_lines_oe(data_lines_oe), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
  .write_n(write_n), .nv_select_n(nv_select_n));

// file: tb/nvsr_dev_model.sv
// Purpose: behavioural nonvolatile sram seen by the host
// Assumes: pins sampled on ref_clk, times shorter than the host waits
// Notes: no pull on the data bus, so a released bus shows a changing pattern
`timescale 1ns/1ps
module nvsr_dev_model #(
  parameter int unsigned ST_CYC = 10,
  parameter int unsigned RC_CYC = 300,
  parameter int unsigned PU_CYC = 8
) (
  // clock and supply
  input wire logic ref_clk,
  input wire logic power_good,
  // pins
  input wire logic [nvsr_pkg::ADDR_W-1:0] addr_lines,
  input wire logic [7:0] host_dout,
  input wire logic host_oe,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic write_n,
  input wire logic nv_select_n,
  output logic [7:0] bus
);
  logic [7:0] mem [nvsr_pkg::ARRAY_BYTES];
  logic [7:0] nv [nvsr_pkg::ARRAY_BYTES];
  logic [7:0] last_reg;
  logic st_prev, rc_prev, req;
  int busy;
  wire rd = !chip_sel_n && !out_gate_n && write_n && nv_select_n;
  wire wr = !chip_sel_n && !write_n && nv_select_n;
  wire st = !chip_sel_n && !write_n && out_gate_n && !nv_select_n;
  wire rc = !chip_sel_n && !out_gate_n && write_n && !nv_select_n;
  assign bus = host_oe ? host_dout : (rd && busy == 0 && !req) ? mem[addr_lines] : ~last_reg;
  initial begin
    busy = 0;
    req = 1'b1;
    st_prev = 1'b0;
    rc_prev = 1'b0;
    last_reg = 8'h00;
    foreach (mem[i]) begin
      mem[i] = 8'h00;
      nv[i] = 8'h00;
    end
  end
  always @(posedge ref_clk) begin
    last_reg <= bus;
    st_prev <= st;
    rc_prev <= rc;
    if (!power_good) begin
      req <= 1'b1;
      busy <= 0;
    end else if (busy != 0) begin
      busy <= busy - 1;
    end else if (req) begin
      req <= 1'b0;
      mem <= nv;
      busy <= PU_CYC;
    end else if (st && !st_prev) begin
      nv <= mem;
      busy <= ST_CYC;
    end else if (rc && !rc_prev) begin
      mem <= nv;
      busy <= RC_CYC;
    end else if (wr) begin
      mem[addr_lines] <= host_dout;
    end
  end
endmodule // nvsr_dev_model

// file: tb/testbench.sv
// Purpose: self-checking bench for the nvsr host against a device model
// Assumes: shortened store and restore waits
// Notes: reference arrays track sram and shadow contents
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rst, power_good, cmd_valid, cmd_ready, rsp_valid, rsp_err;
  logic oe, cs_n, og_n, we_n, nv_n, er, busy;
  logic [1:0] cmd_op;
  logic [nvsr_pkg::ADDR_W-1:0] cmd_addr, addr;
  logic [7:0] cmd_wdata, rsp_rdata, dout, din, rd;
  logic [7:0] bm [8192];
  logic [7:0] bn [8192];
  logic [12:0] aq [$];
  int mismatches, checks_done, cycles, n0;
  nvsr_host #(.STORE_CYC(20), .RESTORE_CYC(20)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .power_good(power_good), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_rdata(rsp_rdata), .busy(busy), .addr_lines(addr), .data_lines_in(din),
    .data_lines_out(dout), .data_lines_oe(oe), .chip_sel_n(cs_n), .out_gate_n(og_n),
    .write_n(we_n), .nv_select_n(nv_n));
  nvsr_dev_model u_dev (.ref_clk(ref_clk), .power_good(power_good), .addr_lines(addr),
    .host_dout(dout), .host_oe(oe), .chip_sel_n(cs_n), .out_gate_n(og_n), .write_n(we_n),
    .nv_select_n(nv_n), .bus(din));
  task automatic stop_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // entered and left at a falling edge; the request is raised once cmd_ready is seen and held one cycle
  task automatic do_cmd(input logic [1:0] op, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 4000) mismatches++;
    rd = rsp_rdata;
    er = rsp_err;
    @(negedge ref_clk);
  endtask
  task automatic wr_all();
    foreach (aq[i]) begin
      bm[aq[i]] = 8'($urandom());
      do_cmd(2'h1, aq[i], bm[aq[i]]);
      check({7'h00, er}, 8'h00);
    end
  endtask
  task automatic rd_all();
    foreach (aq[i]) begin
      do_cmd(2'h0, aq[i], 8'h00);
      check(rd, bm[aq[i]]);
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    rst = 1'b1;
    power_good = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_addr = 13'h0000;
    cmd_wdata = 8'h00;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    void'($urandom(32'h8A19));
    foreach (bm[i]) begin
      bm[i] = 8'h00;
      bn[i] = 8'h00;
    end
    aq = '{13'h0000, 13'h1FFF};
    repeat (6) aq.push_back(13'($urandom()));
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    check({6'h00, busy, cmd_ready}, 8'h02);
    // the power-up recall window (20 cycles here) must pass before any access
    n0 = 0;
    while (cmd_ready !== 1'b1 && n0 < 200) begin
      @(negedge ref_clk);
      n0++;
    end
    check({7'h00, n0 > 20}, 8'h01);
    check({6'h00, busy, cmd_ready}, 8'h01);
    wr_all();
    rd_all();
    do_cmd(2'h2, 13'h0000, 8'h00);
    check({7'h00, er}, 8'h00);
    bn = bm;
    // new sram contents must not leak into the shadow copy
    wr_all();
    rd_all();
    repeat (2) begin
      do_cmd(2'h3, 13'h0000, 8'h00);
      check({7'h00, er}, 8'h00);
      bm = bn;
      rd_all();
    end
    wr_all();
    power_good = 1'b0;
    repeat (10) @(negedge ref_clk);
    power_good = 1'b1;
    bm = bn;
    rd_all();
    stop_test();
  end
endmodule // testbench
